// File: logic/ptd_channel.sv
/*
 * One delay channel: fires a single-cycle pulse when the counter
 * reaches its delay while armed. Assumes the owner clears armed.
 */
`timescale 1ns/1ps
module ptd_channel (
	input wire logic sys_clk_i, // Peripheral clock
	input wire logic rst_i, // Async reset, high
	ptd_chan_if.chan ch // Delay, count and fire
);
	logic fire_ff;

	// One clock per hit, only on a counter advance
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fire_ff <= 1'b0;
		end else begin
			fire_ff <= ch.armed && ch.tick && (ch.count == ch.delay); // R14 R25
		end
	end
	assign ch.fire = fire_ff;
endmodule

// File: logic/ptd_pkg.sv
/*
 * Package for the programmable trigger delay block: register indices,
 * field positions, reset values and timing constants.
 * Assumes an 8-bit register port with one-cycle read latency.
 */
package ptd_pkg;
	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam logic [4:0] ADDR_STATUS_CTRL = 5'h00;
	localparam logic [4:0] ADDR_CTRL_ONE = 5'h01;
	localparam logic [4:0] ADDR_CTRL_TWO = 5'h02;
	localparam logic [4:0] ADDR_OUT_GATE = 5'h03;
	localparam logic [4:0] ADDR_LIMIT_HI = 5'h04;
	localparam logic [4:0] ADDR_LIMIT_LO = 5'h05;
	localparam logic [4:0] ADDR_COUNT_HI = 5'h06;
	localparam logic [4:0] ADDR_COUNT_LO = 5'h07;
	localparam logic [4:0] ADDR_IRQ_HI = 5'h08;
	localparam logic [4:0] ADDR_IRQ_LO = 5'h09;
	localparam logic [4:0] ADDR_DAC_HI = 5'h0a;
	localparam logic [4:0] ADDR_DAC_LO = 5'h0b;
	localparam logic [4:0] ADDR_DLY_BASE = 5'h10;
	// ----------------------------------------------------------------
	// Status and control field positions
	// ----------------------------------------------------------------
	localparam int SC_ENABLE = 7;
	localparam int SC_FLAG = 6;
	localparam int SC_IRQ_EN = 5;
	localparam int SC_LOAD_TIMING = 4;
	localparam int SC_PATH_HI = 3;
	localparam int SC_PATH_LO = 2;
	localparam int SC_DAC_EN = 1;
	localparam int SC_COMMIT = 0;
	localparam int C1_DIV_HI = 7;
	localparam int C1_DIV_LO = 5;
	localparam int C1_TRIG_HI = 4;
	localparam int C1_TRIG_LO = 2;
	localparam int C1_REPEAT = 1;
	localparam int C1_DIVIDER_MULTIPLY = 0;
	localparam int C2_SOFT = 0;
	// ----------------------------------------------------------------
	// Encodings, resets and timing
	// ----------------------------------------------------------------
	localparam logic [2:0] TRIG_CONV_DONE = 3'h0;
	localparam logic [2:0] TRIG_COMPARATOR = 3'h1;
	localparam logic [2:0] TRIG_SOFT = 3'h7;
	localparam logic [1:0] PATH_BYPASS = 2'h0;
	localparam logic [1:0] PATH_CHAN_A = 2'h1;
	localparam logic [1:0] PATH_OR_ALL = 2'h2;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_LIMIT = 16'hffff;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [7:0] DIVIDER_MULTIPLY_FACTOR = 8'h14;
	localparam int NUM_CH = 8;
endpackage

// File: logic/ptd_reg_if.sv
/*
 * Interface carrying one channel's active delay and pulse to the
 * channel module. Assumes both ends share sys_clk_i.
 */
`timescale 1ns/1ps
interface ptd_chan_if;
	logic [15:0] delay;
	logic armed;
	logic [15:0] count;
	logic tick;
	logic fire;
	modport ctrl (output delay, output armed, output count, output tick,
		input fire);
	modport chan (input delay, input armed, input count, input tick,
		output fire);
endinterface

// File: logic/ptd_top.sv
/*
 * Programmable trigger delay: prescaled 16-bit up-counter, eight delay
 * channels, DAC pulse train and compare flag behind an 8-bit port.
 * Assumes synchronous trigger sources except the comparator pin.
 */
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
// Function
// R1 - Divider code selects divide by 1..128
// R2 - Multiply bit scales divider by twenty
// R3 - Trigger select: done, comparator, software restart
// R4 - Repeat bit: one-shot or continuous
// R5 - Chain enable uses acknowledge to rearm
// R6 - Output enable passes or forces low
// R7 - Only channel 0 drives converter trigger
// R8 - Counter returns to zero at limit
// R9 - Reads return active, not buffered values
// R10 - Sixteen-bit up-counter, bytes read-only
// R11 - Byte read freezes coherent pair
// R12 - Flag sets on match; irq gated
// R13 - DAC pulse every interval counts
// R14 - Channel delay from trigger to output
// R15 - Prescale sets count granularity
// R16 - Software picks smallest prescaler
// R17 - Single reset, single clock
// R18 - Write one clears compare flag
// R19 - Software spaces delays, keeps channel 0
// R20 - Enable clear stops counter, kills triggers
// R21 - Commit copies buffers now or later
// R22 - Buffer writes ignored while commit pending
// R23 - Path select bypass, channel A, OR
// R24 - One-shot idles until next trigger
// R25 - Trigger pulses last one clock
module ptd_top (
	input wire logic sys_clk_i, // Peripheral bus clock
	input wire logic rst_i, // Async reset, high
	input wire logic [4:0] addr_i, // Register index
	input wire logic [7:0] wdata_i, // Write data
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	output logic [7:0] rdata_o, // Read data, next cycle
	input wire logic converter_done_i, // Conversion complete
	input wire logic comparator_out_i, // Comparator, async
	input wire logic [7:1] trig_ack_i, // Channel acknowledges
	output logic [7:0] chan_trig_o, // Channel triggers
	output logic adc_trig_o, // Converter hw trigger
	output logic dac_trig_o, // DAC trigger pulse
	output logic irq_o // Compare interrupt
);
	localparam int N = ptd_pkg::NUM_CH;

	logic [7:0] sc_ff, c1_ff, c2_ff, gate_ff;
	logic flag_ff, commit_ff;
	logic [15:0] buf_lim_ff, act_lim_ff, buf_irq_ff, act_irq_ff;
	logic [15:0] buf_dac_ff, act_dac_ff;
	logic [15:0] buf_dly_ff [N];
	logic [15:0] act_dly_ff [N];
	logic [15:0] cnt_ff, hold_ff, dac_cnt_ff;
	logic hold_valid_ff, hold_lo_ff, running_ff;
	logic [11:0] pre_ff;
	logic [2:0] cmp_sync_ff;
	logic cmp_state_ff, trig_in_d_ff;
	logic [7:0] rdata_ff, out_ff;
	logic dac_ff;
	logic [N-1:0] armed_ff, fire, ack_all;

	// ----------------------------------------------------------------
	// Field decode
	// ----------------------------------------------------------------
	logic enable, repeat_run, divider_multiply, load_late, wr_sc, soft_go, tick;
	logic [1:0] path;
	logic [2:0] trig_sel;
	logic [11:0] pre_limit;
	logic trig_level, trig_edge, start, at_limit, do_load;
	assign enable = sc_ff[ptd_pkg::SC_ENABLE];
	assign load_late = sc_ff[ptd_pkg::SC_LOAD_TIMING];
	assign path = sc_ff[ptd_pkg::SC_PATH_HI:ptd_pkg::SC_PATH_LO];
	assign trig_sel = c1_ff[ptd_pkg::C1_TRIG_HI:ptd_pkg::C1_TRIG_LO];
	assign repeat_run = c1_ff[ptd_pkg::C1_REPEAT]; // R4
	assign divider_multiply = c1_ff[ptd_pkg::C1_DIVIDER_MULTIPLY];
	assign wr_sc = wr_i && addr_i == ptd_pkg::ADDR_STATUS_CTRL;

	// Factor = 2^code, times twenty when multiplied
	always_comb begin
		logic [11:0] base;
		base = 12'h001 << c1_ff[ptd_pkg::C1_DIV_HI:ptd_pkg::C1_DIV_LO]; // R1
		pre_limit = divider_multiply ? 12'(base * 12'(ptd_pkg::DIVIDER_MULTIPLY_FACTOR)) : base; // R2
	end
	assign tick = running_ff && (pre_ff == pre_limit - 12'h001); // R15

	// ----------------------------------------------------------------
	// Trigger input
	// ----------------------------------------------------------------
	// Comparator pin: change accepted once stages two and three agree
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmp_sync_ff <= 3'h0;
			cmp_state_ff <= 1'b0;
		end else begin
			cmp_sync_ff <= {cmp_sync_ff[1:0], comparator_out_i};
			if (cmp_sync_ff[1] == cmp_sync_ff[2]) begin
				cmp_state_ff <= cmp_sync_ff[2];
			end
		end
	end

	always_comb begin
		case (trig_sel) // R3
			ptd_pkg::TRIG_CONV_DONE: trig_level = converter_done_i;
			ptd_pkg::TRIG_COMPARATOR: trig_level = cmp_state_ff;
			default: trig_level = 1'b0;
		endcase
	end
	assign soft_go = wr_i && addr_i == ptd_pkg::ADDR_CTRL_TWO &&
		wdata_i[ptd_pkg::C2_SOFT] && trig_sel == ptd_pkg::TRIG_SOFT; // R3
	assign trig_edge = trig_level && !trig_in_d_ff;
	assign start = enable && (trig_edge || soft_go);
	assign at_limit = tick && cnt_ff == act_lim_ff;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			trig_in_d_ff <= 1'b0;
		end else begin
			trig_in_d_ff <= trig_level;
		end
	end

	// ----------------------------------------------------------------
	// Counter and prescaler
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_ff <= ptd_pkg::RST_WORD; // R17
			pre_ff <= 12'h000;
			running_ff <= 1'b0;
		end else if (!enable) begin
			cnt_ff <= ptd_pkg::RST_WORD; // R20
			pre_ff <= 12'h000;
			running_ff <= 1'b0;
		end else if (start) begin
			cnt_ff <= ptd_pkg::RST_WORD; // R3
			pre_ff <= 12'h000;
			running_ff <= 1'b1;
		end else if (running_ff) begin
			pre_ff <= tick ? 12'h000 : pre_ff + 12'h001;
			if (at_limit) begin
				cnt_ff <= ptd_pkg::RST_WORD; // R8
				running_ff <= repeat_run; // R24
			end else if (tick) begin
				cnt_ff <= cnt_ff + 16'h0001; // R10
			end
		end
	end

	// ----------------------------------------------------------------
	// Channels and arming
	// ----------------------------------------------------------------
	assign ack_all = {trig_ack_i, 1'b0};
	// All channels rearm on start or repeat wrap, chained ones also on acknowledge
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			armed_ff <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				if (!enable) begin
					armed_ff[i] <= 1'b0;
				end else if (start || (at_limit && repeat_run)) begin
					armed_ff[i] <= 1'b1;
				end else if (fire[i]) begin
					armed_ff[i] <= 1'b0;
				end else if (c2_ff[i] && ack_all[i]) begin
					armed_ff[i] <= 1'b1; // R5
				end
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gen_ch
			ptd_chan_if cif ();
			assign cif.delay = act_dly_ff[g];
			assign cif.armed = armed_ff[g];
			assign cif.count = cnt_ff;
			assign cif.tick = tick;
			assign fire[g] = cif.fire;
			ptd_channel i_ptd_channel (
				.sys_clk_i(sys_clk_i),
				.rst_i(rst_i),
				.ch(cif.chan)
			);
		end
	endgenerate

	// Path select then per-channel gate; reserved code drives nothing
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			out_ff <= 8'h00;
		end else if (!enable) begin
			out_ff <= 8'h00; // R20
		end else begin
			case (path) // R23
				ptd_pkg::PATH_BYPASS: out_ff <= {N{start}} & gate_ff; // R6
				ptd_pkg::PATH_CHAN_A: out_ff <= {7'h00, fire[0]} & gate_ff;
				ptd_pkg::PATH_OR_ALL: out_ff <= fire & gate_ff; // R6
				default: out_ff <= 8'h00;
			endcase
		end
	end
	assign chan_trig_o = out_ff; // R25
	assign adc_trig_o = out_ff[0]; // R7

	// ----------------------------------------------------------------
	// DAC pulses
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dac_cnt_ff <= ptd_pkg::RST_WORD;
			dac_ff <= 1'b0;
		end else begin
			dac_ff <= 1'b0;
			if (!enable || start) begin
				dac_cnt_ff <= ptd_pkg::RST_WORD;
			end else if (tick) begin
				if (dac_cnt_ff + 16'h0001 >= act_dac_ff) begin
					dac_cnt_ff <= ptd_pkg::RST_WORD;
					dac_ff <= sc_ff[ptd_pkg::SC_DAC_EN]; // R13 R25
				end else begin
					dac_cnt_ff <= dac_cnt_ff + 16'h0001;
				end
			end
		end
	end
	assign dac_trig_o = dac_ff;

	// ----------------------------------------------------------------
	// Control registers, flag and commit
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sc_ff <= ptd_pkg::RST_BYTE;
			c1_ff <= ptd_pkg::RST_BYTE;
			c2_ff <= ptd_pkg::RST_BYTE;
			gate_ff <= ptd_pkg::RST_BYTE;
		end else if (wr_i) begin
			if (addr_i == ptd_pkg::ADDR_STATUS_CTRL) begin
				sc_ff <= wdata_i;
			end
			if (addr_i == ptd_pkg::ADDR_CTRL_ONE) begin
				c1_ff <= wdata_i;
			end
			if (addr_i == ptd_pkg::ADDR_CTRL_TWO) begin
				c2_ff <= {wdata_i[7:1], 1'b0}; // R5
			end
			if (addr_i == ptd_pkg::ADDR_OUT_GATE) begin
				gate_ff <= wdata_i;
			end
		end
	end

	// Set wins over a simultaneous write-one clear
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			flag_ff <= 1'b0;
		end else if (running_ff && tick && cnt_ff == act_irq_ff) begin
			flag_ff <= 1'b1; // R12
		end else if (wr_sc && wdata_i[ptd_pkg::SC_FLAG]) begin
			flag_ff <= 1'b0; // R18
		end
	end
	assign irq_o = flag_ff && sc_ff[ptd_pkg::SC_IRQ_EN]; // R12

	assign do_load = commit_ff && (!load_late ||
		(repeat_run ? at_limit : start)); // R21
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			commit_ff <= 1'b0;
		end else if (do_load) begin
			commit_ff <= 1'b0; // R21
		end else if (wr_sc && wdata_i[ptd_pkg::SC_COMMIT]) begin
			commit_ff <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Buffered and active timing values
	// ----------------------------------------------------------------
	logic buf_wr;
	assign buf_wr = wr_i && !commit_ff; // R22
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			buf_lim_ff <= ptd_pkg::RST_LIMIT;
			buf_irq_ff <= ptd_pkg::RST_LIMIT;
			buf_dac_ff <= ptd_pkg::RST_LIMIT;
			for (int i = 0; i < N; i++) buf_dly_ff[i] <= ptd_pkg::RST_LIMIT;
		end else if (buf_wr) begin
			case (addr_i)
				ptd_pkg::ADDR_LIMIT_HI: buf_lim_ff[15:8] <= wdata_i;
				ptd_pkg::ADDR_LIMIT_LO: buf_lim_ff[7:0] <= wdata_i;
				ptd_pkg::ADDR_IRQ_HI: buf_irq_ff[15:8] <= wdata_i;
				ptd_pkg::ADDR_IRQ_LO: buf_irq_ff[7:0] <= wdata_i;
				ptd_pkg::ADDR_DAC_HI: buf_dac_ff[15:8] <= wdata_i;
				ptd_pkg::ADDR_DAC_LO: buf_dac_ff[7:0] <= wdata_i;
				default: begin
					if (addr_i[4]) begin
						if (addr_i[0]) begin
							buf_dly_ff[addr_i[3:1]][7:0] <= wdata_i;
						end else begin
							buf_dly_ff[addr_i[3:1]][15:8] <= wdata_i;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			act_lim_ff <= ptd_pkg::RST_LIMIT;
			act_irq_ff <= ptd_pkg::RST_LIMIT;
			act_dac_ff <= ptd_pkg::RST_LIMIT;
			for (int i = 0; i < N; i++) act_dly_ff[i] <= ptd_pkg::RST_LIMIT;
		end else if (do_load) begin
			act_lim_ff <= buf_lim_ff; // R21
			act_irq_ff <= buf_irq_ff;
			act_dac_ff <= buf_dac_ff;
			for (int i = 0; i < N; i++) act_dly_ff[i] <= buf_dly_ff[i];
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	// Either byte read freezes both; the opposite byte releases it
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			hold_ff <= ptd_pkg::RST_WORD;
			hold_valid_ff <= 1'b0;
			hold_lo_ff <= 1'b0;
		end else if (rd_i && (addr_i == ptd_pkg::ADDR_COUNT_HI ||
				addr_i == ptd_pkg::ADDR_COUNT_LO)) begin
			if (!hold_valid_ff) begin
				hold_ff <= cnt_ff; // R11
				hold_valid_ff <= 1'b1;
				hold_lo_ff <= addr_i[0];
			end else if (addr_i[0] != hold_lo_ff) begin
				hold_valid_ff <= 1'b0; // R11
			end
		end
	end

	logic [15:0] cnt_view;
	assign cnt_view = hold_valid_ff ? hold_ff : cnt_ff;
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_ff <= 8'h00;
		end else if (rd_i) begin
			case (addr_i) // R9
				ptd_pkg::ADDR_STATUS_CTRL: rdata_ff <= {sc_ff[7],
					flag_ff, sc_ff[5:1], commit_ff};
				ptd_pkg::ADDR_CTRL_ONE: rdata_ff <= c1_ff;
				ptd_pkg::ADDR_CTRL_TWO: rdata_ff <= c2_ff;
				ptd_pkg::ADDR_OUT_GATE: rdata_ff <= gate_ff;
				ptd_pkg::ADDR_LIMIT_HI: rdata_ff <= act_lim_ff[15:8];
				ptd_pkg::ADDR_LIMIT_LO: rdata_ff <= act_lim_ff[7:0];
				ptd_pkg::ADDR_COUNT_HI: rdata_ff <= cnt_view[15:8]; // R10
				ptd_pkg::ADDR_COUNT_LO: rdata_ff <= cnt_view[7:0];
				ptd_pkg::ADDR_IRQ_HI: rdata_ff <= act_irq_ff[15:8];
				ptd_pkg::ADDR_IRQ_LO: rdata_ff <= act_irq_ff[7:0];
				ptd_pkg::ADDR_DAC_HI: rdata_ff <= act_dac_ff[15:8];
				ptd_pkg::ADDR_DAC_LO: rdata_ff <= act_dac_ff[7:0];
				default: begin
					if (addr_i[4]) begin
						rdata_ff <= addr_i[0] ?
							act_dly_ff[addr_i[3:1]][7:0] :
							act_dly_ff[addr_i[3:1]][15:8];
					end else begin
						rdata_ff <= 8'h00;
					end
				end
			endcase
		end
	end
	assign rdata_o = rdata_ff;
endmodule

// File: verif/programmable_trigger_delay_bench.sv
/*
 * Self-checking bench for ptd_top: register tasks and scenarios.
 * Assumes the checker is bound from its own file.
 */
`timescale 1ns/1ps
module programmable_trigger_delay_bench;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [4:0] addr_i = 5'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic slow_i = 1'b0;
	logic [7:0] rdata_o, chan_trig_o, d, e;
	logic adc_trig_o, dac_trig_o, irq_o, converter_done_i, comparator_out_i;
	logic [7:1] trig_ack_i;
	int error_cnt = 0;
	int checked = 0;
	int cyc = 0;
	int n[4] = '{default: 0};
	int dn[4];
	int f, lt;
	logic [12:0] rv[10] = '{13'h0000, 13'h0100, 13'h0200, 13'h0300,
		13'h04ff, 13'h09ff, 13'h0aff, 13'h1fff, 13'h0600, 13'h0700};
	logic [2:0] ts[4] = '{3'h0, 3'h0, 3'h1, 3'h7};
	int tk[4] = '{1, 2, 2, 1};
	int te[4] = '{1, 0, 1, 0};

	ptd_top i_ptd_top (.sys_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .converter_done_i, .comparator_out_i, .trig_ack_i,
		.chan_trig_o, .adc_trig_o, .dac_trig_o, .irq_o);
	ptd_far_model i_ptd_far_model (.sys_clk_i, .slow_i, .chan_trig_o,
		.converter_done_i, .comparator_out_i, .trig_ack_i);

	initial forever #5 sys_clk_i = ~sys_clk_i;
	initial begin
		repeat (4) @(posedge sys_clk_i);
		rst_i <= 1'b0;
	end
	// Pulse tallies; ceiling is about five times the planned run
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		n[0] <= n[0] + chan_trig_o[0];
		n[1] <= n[1] + chan_trig_o[1];
		n[2] <= n[2] + adc_trig_o;
		n[3] <= n[3] + dac_trig_o;
		if (cyc == 20000) begin
			error_cnt++;
			$display("Error at %0t: timeout", $time);
			tally_and_finish();
		end
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [7:0] v);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		@(negedge sys_clk_i);
		v = rdata_o;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [4:0] a, input logic [7:0] x);
		logic [7:0] v;
		rd(a, v);
		chk(v, x);
	endtask
	task automatic rng(input int v, input int lo, input int hi);
		checked++;
		if (v < lo || v > hi) begin
			error_cnt++;
			$display("Error at %0t: %0d not in %0d..%0d", $time, v, lo, hi);
		end
	endtask
	task automatic setup(input logic [7:0] c1, input logic [15:0] lim,
		input logic [15:0] dly, input logic [7:0] sc);
		wr(5'h01, c1);
		wr(5'h04, lim[15:8]);
		wr(5'h05, lim[7:0]);
		wr(5'h10, dly[15:8]);
		wr(5'h11, dly[7:0]);
		wr(5'h12, dly[15:8]);
		wr(5'h13, dly[7:0]);
		wr(5'h00, sc);
	endtask
	task automatic run(input int kind, input int cycles);
		int s[4];
		s = n;
		if (kind == 0)
			wr(5'h02, 8'h03);
		else
			i_ptd_far_model.kick(kind);
		repeat (cycles) @(posedge sys_clk_i);
		foreach (dn[i]) dn[i] = n[i] - s[i];
	endtask
	task automatic lat(output int t);
		int s;
		s = n[0];
		t = 0;
		wr(5'h02, 8'h03);
		while (n[0] == s && t < 3000) begin
			@(posedge sys_clk_i);
			t++;
		end
	endtask
	task automatic done(input string s);
		$display("Test %s finished, %0d errors so far", s, error_cnt);
	endtask
	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		@(negedge rst_i);
		foreach (rv[i]) rchk(rv[i][12:8], rv[i][7:0]);
		wr(5'h03, 8'hff);
		rchk(5'h03, 8'hff);
		done("reset");
		for (int c = 0; c < 9; c++) begin
			f = (c == 8) ? 20 : (1 << c);
			setup({(c == 8) ? 3'h0 : c[2:0], 3'h7, 1'b0, c == 8},
				16'hffff, 16'h0008, 8'h89);
			lat(lt);
			rng(lt, 9 * f + 2, 9 * f + 4);
		end
		rchk(5'h02, 8'h02);
		setup(8'h1c, 16'hffff, 16'h0008, 8'h81);
		lat(lt);
		rng(lt, 0, 6);
		done("prescale");
		setup(8'h1c, 16'hffff, 16'h0008, 8'h89);
		wr(5'h03, 8'h00);
		run(0, 30);
		rng(dn[0] + dn[2], 0, 0);
		wr(5'h03, 8'h02);
		run(0, 30);
		rng(dn[1], 1, 1);
		rng(dn[0] + dn[2], 0, 0);
		wr(5'h03, 8'h03);
		wr(5'h00, 8'h84);
		run(0, 30);
		rng(dn[1], 0, 0);
		rng(dn[0] + dn[2], 2, 2);
		done("gate");
		setup(8'h1c, 16'h0014, 16'h0005, 8'h89);
		run(0, 120);
		rng(dn[0], 1, 1);
		rchk(5'h06, 8'h00);
		rchk(5'h07, 8'h00);
		wr(5'h06, 8'h55);
		rchk(5'h06, 8'h00);
		rchk(5'h07, 8'h00);
		wr(5'h01, 8'h1e);
		run(0, 210);
		rng(dn[0], 9, 11);
		rd(5'h07, d);
		repeat (7) @(posedge sys_clk_i);
		rd(5'h07, e);
		chk(e, d);
		rd(5'h07, e);
		chk(e, d);
		rchk(5'h06, 8'h00);
		done("modes");
		wr(5'h01, 8'h1c);
		wr(5'h05, 8'h40);
		wr(5'h00, 8'h99);
		rchk(5'h00, 8'h99);
		rchk(5'h05, 8'h14);
		wr(5'h05, 8'h33);
		run(0, 40);
		rchk(5'h00, 8'h98);
		rchk(5'h05, 8'h40);
		done("commit");
		wr(5'h08, 8'h00);
		wr(5'h09, 8'h0a);
		setup(8'h1c, 16'h0014, 16'h0005, 8'h89);
		run(0, 60);
		rchk(5'h00, 8'hc8);
		chk({7'h00, irq_o}, 8'h00);
		wr(5'h00, 8'ha8);
		@(negedge sys_clk_i);
		chk({7'h00, irq_o}, 8'h01);
		wr(5'h00, 8'he8);
		rchk(5'h00, 8'ha8);
		chk({7'h00, irq_o}, 8'h00);
		wr(5'h00, 8'h88);
		done("flag");
		wr(5'h0a, 8'h00);
		wr(5'h0b, 8'h04);
		wr(5'h01, 8'h1e);
		wr(5'h00, 8'h8b);
		run(0, 210);
		rng(dn[3], 45, 56);
		wr(5'h00, 8'h08);
		// A pulse launched on the disabling edge is not a fault
		repeat (2) @(posedge sys_clk_i);
		run(0, 40);
		rng(dn[0] + dn[3], 0, 0);
		rd(5'h07, d);
		rd(5'h06, e);
		repeat (5) @(posedge sys_clk_i);
		rd(5'h07, e);
		chk(e, d);
		done("dac");
		wr(5'h01, 8'h00);
		wr(5'h00, 8'h89);
		slow_i <= 1'b1;
		repeat (40) @(posedge sys_clk_i);
		foreach (ts[k]) begin
			wr(5'h01, {3'h0, ts[k], 2'h0});
			run(tk[k], 40);
			rng(dn[0], te[k], te[k]);
		end
		done("sources");
		tally_and_finish();
	end
endmodule

// File: verif/ptd_far_model.sv
/*
 * Far side of the trigger delay block: converter and comparator
 * trigger sources, and a converter that acknowledges channel triggers.
 * Assumes the bench calls kick from its own sequence.
 */
`timescale 1ns/1ps
module ptd_far_model (
	input wire logic sys_clk_i, // Peripheral clock
	input wire logic slow_i, // Late acknowledge
	input wire logic [7:0] chan_trig_o, // Triggers from block
	output logic converter_done_i, // Conversion complete
	output logic comparator_out_i, // Comparator level
	output logic [7:1] trig_ack_i // Acknowledges
);
	logic [7:1] conv_sr [8] = '{default: 7'h00};
	initial begin
		converter_done_i = 1'b0;
		comparator_out_i = 1'b0;
	end
	// Conversion takes two or eight cycles before the acknowledge
	always @(posedge sys_clk_i) begin
		conv_sr[0] <= chan_trig_o[7:1];
		for (int i = 1; i < 8; i++)
			conv_sr[i] <= conv_sr[i - 1];
	end
	assign trig_ack_i = slow_i ? conv_sr[7] : conv_sr[1];
	task automatic kick(input int src);
		if (src == 1) begin
			@(posedge sys_clk_i);
			converter_done_i <= 1'b1;
			@(posedge sys_clk_i);
			converter_done_i <= 1'b0;
		end else begin
			// Comparator edges land between clock edges on purpose
			#3 comparator_out_i = 1'b1;
			repeat (4) @(posedge sys_clk_i);
			#3 comparator_out_i = 1'b0;
		end
	endtask
endmodule

// File: verif/ptd_top_props.sv
/*
 * Port-level checker for ptd_top: trigger, flag and register timing.
 * Assumes the bind at the foot attaches it to every ptd_top.
 */
`timescale 1ns/1ps
module ptd_top_props (
	input wire logic sys_clk_i, // Peripheral clock
	input wire logic rst_i, // Async reset, high
	input wire logic [4:0] addr_i, // Register index
	input wire logic [7:0] wdata_i, // Write data
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	input wire logic [7:0] rdata_o, // Read data
	input wire logic converter_done_i, // Conversion complete
	input wire logic comparator_out_i, // Comparator level
	input wire logic [7:1] trig_ack_i, // Acknowledges
	input wire logic [7:0] chan_trig_o, // Channel triggers
	input wire logic adc_trig_o, // Converter trigger
	input wire logic dac_trig_o, // DAC pulse
	input wire logic irq_o // Compare interrupt
);
	default clocking dc @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);
	logic sc_wr;
	assign sc_wr = wr_i && addr_i == ptd_pkg::ADDR_STATUS_CTRL;
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_adc_from_chan0: assert property (adc_trig_o == chan_trig_o[0])
		else $error("converter trigger differs from channel 0");
	a_chan_one_cycle: assert property (|chan_trig_o |=>
		(chan_trig_o & $past(chan_trig_o)) == 8'h00)
		else $error("channel trigger longer than one cycle");
	a_irq_gated: assert property (sc_wr &&
		!wdata_i[ptd_pkg::SC_IRQ_EN] |=> !irq_o)
		else $error("interrupt raised while disabled");
	// Three cycles allow a pulse already in the output register
	a_gate_closed: assert property (wr_i &&
		addr_i == ptd_pkg::ADDR_OUT_GATE && wdata_i == 8'h00 |->
		##3 (chan_trig_o == 8'h00) [*6])
		else $error("closed channel still triggers");
	a_off_quiet: assert property (sc_wr &&
		!wdata_i[ptd_pkg::SC_ENABLE] |->
		##3 (chan_trig_o == 8'h00 && !dac_trig_o) [*6])
		else $error("trigger while block disabled");
	a_dac_off: assert property (sc_wr &&
		!wdata_i[ptd_pkg::SC_DAC_EN] |-> ##3 !dac_trig_o [*6])
		else $error("DAC pulse while DAC output off");
	a_soft_reads_zero: assert property (rd_i &&
		addr_i == ptd_pkg::ADDR_CTRL_TWO |=>
		!rdata_o[ptd_pkg::C2_SOFT])
		else $error("soft trigger bit reads back set");
	a_gate_reads: assert property (wr_i &&
		addr_i == ptd_pkg::ADDR_OUT_GATE ##2 rd_i &&
		addr_i == ptd_pkg::ADDR_OUT_GATE |=> rdata_o == $past(wdata_i, 3))
		else $error("output gate reads back wrong");
	a_reset_quiet: assert property ($fell(rst_i) |->
		chan_trig_o == 8'h00 && !dac_trig_o && !irq_o)
		else $error("output active right after reset");
endmodule
bind ptd_top ptd_top_props i_ptd_top_props (.sys_clk_i, .rst_i, .addr_i,
	.wdata_i, .wr_i, .rd_i, .rdata_o, .converter_done_i, .comparator_out_i,
	.trig_ack_i, .chan_trig_o, .adc_trig_o, .dac_trig_o, .irq_o);
